// ---- rtl/slse_pkg.sv ----
package slse_pkg;
   // frame geometry
   localparam int SAMPLE_W = 12;
   localparam int WORD_W = 14;
   localparam int FRAME_W = 16;
   localparam int CB_FIRST_POS = 12;
   localparam int CB_SECOND_POS = 13;
   localparam int CLK_POS = 14;
   localparam int DB_POS = 15;
   localparam int BITCNT_W = 4;
   localparam logic [BITCNT_W-1:0] BIT_LAST = 4'hf;

   // synchronization sequence
   localparam logic [FRAME_W-1:0] FAS_EVEN = 16'h00ff;
   localparam logic [FRAME_W-1:0] FAS_ODD = 16'hff00;
   localparam int SEQ_CNT_W = 5;
   localparam logic [SEQ_CNT_W-1:0] FAS_LAST = 5'h1f;
   localparam logic [SEQ_CNT_W-1:0] PAS_LAST = 5'h1f;

   // running disparity
   localparam int RD_W = 7;
   localparam logic signed [RD_W-1:0] RD_LIMIT = 7'sh0f;
   localparam logic signed [RD_W-1:0] RD_FRAME_BITS = 7'sh10;

   // scrambler lfsr x^17+x^3+1
   localparam int LFSR_W = 17;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 17'h1ffff;

   // timestamp lfsr x^7+x^6+1, galois form
   localparam int TS_W = 7;
   localparam logic [TS_W-1:0] TS_SEED = 7'h7f;
   localparam logic [TS_W-1:0] TS_TAPS = 7'h60;

   // content of a control bit
   typedef enum logic [1:0] {
      SLSE_CB_USER = 2'h0,
      SLSE_CB_PARITY = 2'h1,
      SLSE_CB_STAMP = 2'h2,
      SLSE_CB_ZERO = 2'h3
   } slse_cb_sel_t;

   typedef enum {SLSE_ST_DATA, SLSE_ST_FAS, SLSE_ST_PAS} slse_state_t;
endpackage

// ---- rtl/slse_prbs_if.sv ----
`timescale 1ns/1ps
interface slse_prbs_if;
   import slse_pkg::*;
   logic advance;
   logic [WORD_W-1:0] prbs;
   modport gen (input advance, output prbs);
   modport user (output advance, input prbs);
endinterface

// ---- rtl/slse_scrambler.sv ----
`timescale 1ns/1ps
module slse_scrambler
   import slse_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   slse_prbs_if.gen prbs_port
);
   logic [LFSR_W-1:0] lfsr;
   logic [LFSR_W-1:0] next_lfsr;

   // fourteen shifts of the fibonacci register in one step
   always_comb begin
      next_lfsr[0] = lfsr[14];
      next_lfsr[1] = lfsr[15];
      next_lfsr[2] = lfsr[16];
      for (int i = 3; i < LFSR_W; i++) begin
         next_lfsr[i] = lfsr[i-3] ^ lfsr[i];
      end
   end

   // register advances once per frame
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         lfsr <= LFSR_SEED;
      end else if (prbs_port.advance) begin
         lfsr <= next_lfsr;
      end
   end

   // only the low word bits reach the data
   assign prbs_port.prbs = lfsr[WORD_W-1:0];
endmodule // slse_scrambler

// ---- rtl/slse_lane_encoder.sv ----
`timescale 1ns/1ps
// Overview of operation
// - each frame is a 14-bit data word plus two overhead bits, 16 bits.
// - data word is a 12-bit sample plus two configurable control bits.
// - the data word is scrambled with a fibonacci lfsr sequence first.
// - clock bit appended, lower 15 bits disparity processed, disparity bit appended.
// - frames are serialized least significant bit first.
// - clock bit inverts on every successive frame.
// - sync trigger starts synchronization only in sync mode, not trigger mode.
// - frame alignment: 32 frames alternating 0x00ff and 0xff00.
// - alignment frames bypass scrambling and disparity processing.
// - next 32 frames carry consecutive scrambler values, disparity processed.
// - frame right after the 64 sync frames carries first valid data.
// - scrambler steps 14 bits per frame, x^17+x^3+1, low 14 bits used.
// - if running disparity would pass +/-15, invert 15 bits, set disparity bit.
module slse_lane_encoder
   import slse_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [SAMPLE_W-1:0] sample_i,
   input wire logic control_bit_first_i,
   input wire logic control_bit_second_i,
   input wire logic [1:0] control_bit_first_sel_i,
   input wire logic [1:0] control_bit_second_sel_i,
   input wire logic sync_mode_i,
   input wire logic sync_trigger_input_i,
   output logic sample_take_o,
   output logic serial_o,
   output logic frame_start_o,
   output logic [FRAME_W-1:0] frame_o,
   output logic in_sync_seq_o
);
   slse_prbs_if prbs_bus ();

   logic [BITCNT_W-1:0] bit_cnt;
   logic [FRAME_W-1:0] shift_reg;
   logic [SEQ_CNT_W-1:0] seq_cnt;
   slse_state_t state;
   logic sync_pending;
   logic clk_bit;
   logic signed [RD_W-1:0] run_disp;
   logic [TS_W-1:0] stamp;

   logic load_en;
   logic sync_hit;
   logic start_seq;
   slse_state_t eff_state;
   logic [SEQ_CNT_W-1:0] eff_cnt;
   logic [WORD_W-1:0] data_word;
   logic [WORD_W-1:0] word_out;
   logic [DB_POS-1:0] low_bits;
   logic signed [RD_W-1:0] disp_plain;
   logic signed [RD_W-1:0] disp_sum;
   logic flip;
   logic [FRAME_W-1:0] next_frame;
   logic signed [RD_W-1:0] next_run_disp;

   // number of ones in the lower frame bits
   function automatic logic [BITCNT_W:0] ones_count(input logic [DB_POS-1:0] v);
      logic [BITCNT_W:0] n;
      n = '0;
      for (int i = 0; i < DB_POS; i++) begin
         n = n + {{BITCNT_W{1'b0}}, v[i]};
      end
      return n;
   endfunction

   // content of one control bit from its selector
   function automatic logic cb_value(input logic [1:0] sel, input logic user_bit,
                                     input logic [SAMPLE_W-1:0] smp, input logic ts_bit);
      logic r;
      r = 1'b0;
      unique case (slse_cb_sel_t'(sel))
         SLSE_CB_USER: r = user_bit;
         SLSE_CB_PARITY: r = ^smp;
         SLSE_CB_STAMP: r = ts_bit;
         SLSE_CB_ZERO: r = 1'b0;
      endcase
      return r;
   endfunction

   slse_scrambler u_scrambler (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .prbs_port(prbs_bus.gen)
   );

   // frame boundary: one enable every 16 bit cycles
   assign load_en = (bit_cnt == BIT_LAST);
   assign sample_take_o = load_en;
   assign prbs_bus.advance = load_en;
   assign sync_hit = sync_trigger_input_i & sync_mode_i;
   assign start_seq = load_en & (sync_pending | sync_hit);

   // bit counter
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         bit_cnt <= BIT_LAST;
      end else begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // trigger held until the next frame boundary; one on the boundary itself starts at once
   // and is consumed there, so it cannot start the sequence a second time a frame later
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sync_pending <= 1'b0;
      end else if (load_en) begin
         sync_pending <= 1'b0;
      end else if (sync_hit) begin
         sync_pending <= 1'b1;
      end
   end

   // state and frame index seen by the frame being built
   always_comb begin
      eff_state = start_seq ? SLSE_ST_FAS : state;
      eff_cnt = start_seq ? '0 : seq_cnt;
   end

   // sequence state machine, moves on frame boundaries
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state <= SLSE_ST_DATA;
         seq_cnt <= '0;
      end else if (load_en) begin
         seq_cnt <= eff_cnt + 5'h01;
         unique case (eff_state)
            SLSE_ST_FAS: begin
               if (eff_cnt == FAS_LAST) begin
                  state <= SLSE_ST_PAS;
               end else begin
                  state <= SLSE_ST_FAS;
               end
            end
            SLSE_ST_PAS: begin
               if (eff_cnt == PAS_LAST) begin
                  state <= SLSE_ST_DATA;
               end else begin
                  state <= SLSE_ST_PAS;
               end
            end
            SLSE_ST_DATA: begin
               state <= SLSE_ST_DATA;
            end
         endcase
      end
   end

   // clock bit flips on every frame
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         clk_bit <= 1'b0;
      end else if (load_en) begin
         clk_bit <= ~clk_bit;
      end
   end

   // timestamp sequence, restarted by each accepted trigger
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         stamp <= TS_SEED;
      end else if (start_seq) begin
         stamp <= TS_SEED;
      end else if (load_en) begin
         stamp <= (stamp >> 1) ^ (stamp[0] ? TS_TAPS : '0);
      end
   end

   // frame assembly: scrambling, clock bit, disparity processing
   always_comb begin
      data_word[SAMPLE_W-1:0] = sample_i;
      data_word[CB_FIRST_POS] = cb_value(control_bit_first_sel_i, control_bit_first_i, sample_i, stamp[0]);
      data_word[CB_SECOND_POS] = cb_value(control_bit_second_sel_i, control_bit_second_i, sample_i, stamp[0]);
      if (eff_state == SLSE_ST_PAS) begin
         word_out = prbs_bus.prbs;
      end else begin
         word_out = data_word ^ prbs_bus.prbs;
      end
      low_bits = {~clk_bit, word_out};
      disp_plain = $signed({1'b0, ones_count(low_bits), 1'b0}) - RD_FRAME_BITS;
      disp_sum = run_disp + disp_plain;
      flip = (disp_sum > RD_LIMIT) || (disp_sum < -RD_LIMIT);
      next_frame = {flip, flip ? ~low_bits : low_bits};
      next_run_disp = flip ? run_disp - disp_plain : disp_sum;
      if (eff_state == SLSE_ST_FAS) begin
         next_frame = eff_cnt[0] ? FAS_ODD : FAS_EVEN;
         next_run_disp = run_disp;
      end
   end

   // running disparity of the lane
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         run_disp <= '0;
      end else if (load_en) begin
         run_disp <= next_run_disp;
      end
   end

   // serializer, least significant bit leaves first
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         shift_reg <= '0;
      end else if (load_en) begin
         shift_reg <= next_frame;
      end else begin
         shift_reg <= shift_reg >> 1;
      end
   end

   // parallel copy of the frame on the line and status
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         frame_o <= '0;
         frame_start_o <= 1'b0;
         in_sync_seq_o <= 1'b0;
      end else begin
         frame_start_o <= load_en;
         if (load_en) begin
            frame_o <= next_frame;
            in_sync_seq_o <= (eff_state != SLSE_ST_DATA);
         end
      end
   end

   assign serial_o = shift_reg[0];
endmodule // slse_lane_encoder

// ---- verification/slse_lane_encoder_asserts.sv ----
`timescale 1ns/1ps
module slse_lane_encoder_asserts
   import slse_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic sync_mode_i,
   input wire logic sync_trigger_input_i,
   input wire logic sample_take_o,
   input wire logic serial_o,
   input wire logic frame_start_o,
   input wire logic [FRAME_W-1:0] frame_o,
   input wire logic in_sync_seq_o
);
   logic [3:0] k;
   logic [5:0] age;
   logic signed [7:0] rd;
   wire clkb = frame_o[CLK_POS] ^ frame_o[DB_POS];
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   sequence data_fs;
      frame_start_o && !in_sync_seq_o;
   endsequence
   // bit index, age of the last accepted trigger, running disparity on the line
   always_ff @(posedge mclk_i) begin
      k <= (sys_rst_i || frame_start_o) ? 4'h1 : k + 4'h1;
      age <= sys_rst_i ? 6'h3f : (sync_trigger_input_i && sync_mode_i) ? 6'h01 : age + 6'(age != 6'h3f);
      rd <= sys_rst_i ? 8'sh00 : rd + (frame_start_o ? 8'(2 * $countones(frame_o) - 16) : 8'sh00);
   end
   chk_take_start: assert property (frame_start_o == ($past(sample_take_o) && !$past(sys_rst_i)))
      else $error("frame start misplaced");
   chk_take_period: assert property (sample_take_o |=> (!sample_take_o) [*8] ##8 sample_take_o)
      else $error("take spacing wrong");
   chk_frame_hold: assert property (!frame_start_o |-> $stable(frame_o) && $stable(in_sync_seq_o))
      else $error("frame changed mid frame");
   chk_serial_lsb: assert property (serial_o == frame_o[frame_start_o ? 4'h0 : k])
      else $error("serial bit order wrong");
   chk_clock_toggle: assert property (data_fs ##16 data_fs |-> clkb != $past(clkb, 16))
      else $error("clock bit did not toggle");
   chk_rd_bound: assert property (rd <= 8'sd15 && rd >= -8'sd15)
      else $error("running disparity out of range");
   chk_sync_head: assert property ($rose(in_sync_seq_o) |-> frame_start_o && frame_o == FAS_EVEN)
      else $error("sequence head wrong");
   chk_trig_gate: assert property ($rose(in_sync_seq_o) |-> age <= 6'd17)
      else $error("sequence without trigger");
endmodule // slse_lane_encoder_asserts

bind slse_lane_encoder slse_lane_encoder_asserts slse_lane_encoder_asserts_i (.mclk_i(mclk_i),
   .sys_rst_i(sys_rst_i), .sync_mode_i(sync_mode_i), .sync_trigger_input_i(sync_trigger_input_i),
   .sample_take_o(sample_take_o), .serial_o(serial_o), .frame_start_o(frame_start_o),
   .frame_o(frame_o), .in_sync_seq_o(in_sync_seq_o));

// ---- verification/slse_rx_model.sv ----
`timescale 1ns/1ps
module slse_rx_model
   import slse_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rx_sync_i,
   input wire logic serial_i,
   input wire logic frame_start_i,
   output logic got_o,
   output logic [FRAME_W-1:0] frame_o,
   output logic [14:0] word_o,
   output logic lost_o,
   output logic valid_o
);
   logic [4:0] n = 5'h10;
   logic ok = 1'b0;
   logic pclk = 1'b0;
   logic [5:0] since = 6'h20;
   wire frame_alignment_sequence = frame_o == FAS_EVEN || frame_o == FAS_ODD;
   wire ck = frame_o[CLK_POS] ^ frame_o[DB_POS];
   initial lost_o = 1'b0;
   // gather bits lsb first and watch the clock bit outside alignment frames
   always @(posedge mclk_i) begin
      frame_o <= {serial_i, frame_o[15:1]};
      n <= frame_start_i ? 5'h01 : n + 5'(n != 5'h10);
      got_o <= n == 5'h0f;
      if (rx_sync_i) lost_o <= 1'b0;
      else if (got_o && ok && !frame_alignment_sequence && ck == pclk) lost_o <= 1'b1;
      if (got_o) ok <= !frame_alignment_sequence && !rx_sync_i;
      if (got_o) pclk <= ck;
   end
   // frames since the last alignment frame; the sequence ends 32 frames after it
   always @(posedge mclk_i) begin
      if (got_o) since <= frame_alignment_sequence ? 6'h00 : since + 6'(since != 6'h20);
   end
   // words after the full sequence are the ones written to the lane's output buffer
   assign valid_o = got_o && !frame_alignment_sequence && since == 6'h20;
   // undo the disparity inversion before descrambling
   assign word_o = (frame_o[DB_POS] && !frame_alignment_sequence) ? ~frame_o[14:0] : frame_o[14:0];
endmodule // slse_rx_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import slse_pkg::*;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, cb1 = 1'b0, cb2 = 1'b0, mode = 1'b0, trig = 1'b0, rx_sync = 1'b0;
   logic [SAMPLE_W-1:0] smp = '0;
   logic [1:0] s1 = 2'h0, s2 = 2'h0;
   logic take, ser, fst, insync, got, lost, vld, clk = 1'b0;
   logic [FRAME_W-1:0] frm_o, rx_f;
   logic [14:0] rx_w;
   logic [31:0] q[$];
   logic [31:0] e;
   logic [LFSR_W-1:0] lf = LFSR_SEED;
   logic [TS_W-1:0] ts = TS_SEED;
   int seq = 64, rd = 0, seed = 13283, n_errors = 0, checks_done = 0;
   slse_lane_encoder slse_lane_encoder_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sample_i(smp),
      .control_bit_first_i(cb1), .control_bit_second_i(cb2), .control_bit_first_sel_i(s1),
      .control_bit_second_sel_i(s2), .sync_mode_i(mode), .sync_trigger_input_i(trig),
      .sample_take_o(take), .serial_o(ser), .frame_start_o(fst), .frame_o(frm_o), .in_sync_seq_o(insync));
   slse_rx_model slse_rx_model_i (.mclk_i(mclk_i), .rx_sync_i(rx_sync), .serial_i(ser),
      .frame_start_i(fst), .got_o(got), .frame_o(rx_f), .word_o(rx_w), .lost_o(lost), .valid_o(vld));
   initial forever #2 mclk_i = ~mclk_i;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (n_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic cbv(input logic [1:0] s, input logic u);
      return s == 2'h0 ? u : s == 2'h1 ? ^smp : s == 2'h2 ? ts[0] : 1'b0;
   endfunction
   // one frame: note what the take edge loads, then move the inputs and maybe trigger
   task automatic frm(input logic t, input logic m);
      logic [14:0] w;
      logic [15:0] f;
      int d;
      @(negedge mclk_i iff take === 1'b1);
      @(posedge mclk_i);
      clk = ~clk;
      w = {clk, (seq < 64 ? 14'h0 : {cbv(s2, cb2), cbv(s1, cb1), smp}) ^ lf[13:0]};
      f = {1'b0, w};
      d = 2 * $countones(w) - 16;
      if (seq < 32) begin
         f = seq[0] ? FAS_ODD : FAS_EVEN;
         w = f[14:0];
      end else if (rd + d > 15 || rd + d < -15) begin
         f = {1'b1, ~w};
         rd = rd - d;
      end else rd = rd + d;
      q.push_back({seq < 64, f, w});
      lf = {lf[13:0] ^ lf[16:3], lf[16:14]};
      // the stamp restarts on the first alignment frame, so the frame after it carries the seed
      ts = seq == 0 ? TS_SEED : ts[0] ? (ts >> 1) ^ TS_TAPS : ts >> 1;
      if (seq < 64) seq++;
      if (t && m) begin
         seq = 0;
      end
      smp <= 12'($random(seed));
      {cb1, cb2, s1, s2} <= 6'($random(seed));
      mode <= m;
      rx_sync <= t & m;
      @(posedge mclk_i);
      rx_sync <= 1'b0;
      trig <= t;
      @(posedge mclk_i);
      trig <= 1'b0;
   endtask
   // compare each frame at its start and again once the receiver holds it
   always @(negedge mclk_i) begin
      if (got === 1'b1) chk({1'b0, rx_f, rx_w}, {1'b0, e[30:0]});
      if (got === 1'b1) chk({31'h0, vld}, {31'h0, ~e[31]});
      if (fst === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         chk({15'h0, insync, frm_o}, {15'h0, e[31:15]});
      end
   end
   // main sequence
   initial begin
      repeat (10) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      repeat (20) frm(1'b0, 1'b0);
      frm(1'b1, 1'b0);
      repeat (4) frm(1'b0, 1'b1);
      frm(1'b1, 1'b1);
      repeat (6) frm(1'b0, 1'b1);
      frm(1'b1, 1'b1);
      repeat (90) frm(1'b0, 1'b1);
      chk({31'h0, lost}, 32'h0);
      close_out();
   end
   // watchdog
   initial begin
      #40000;
      n_errors++;
      close_out();
   end
endmodule // tb_top
